// ### inc/pifc_cfg.svh
// Register map, field positions, reset values and arithmetic constants
`ifndef PIFC_CFG_SVH
`define PIFC_CFG_SVH

`define PIFC_ADDR_W 5
`define PIFC_OFS_CTRL 5'h00
`define PIFC_OFS_WIND 5'h04
`define PIFC_OFS_SEP 5'h08
`define PIFC_OFS_EQAC 5'h0c
`define PIFC_OFS_EQB 5'h10
`define PIFC_OFS_STATUS 5'h14

`define PIFC_F_ADCL 0
`define PIFC_F_ADCR 1
`define PIFC_F_DAC 2
`define PIFC_F_MIX 3
`define PIFC_F_WINDEN 4
`define PIFC_F_SEPEN 5
`define PIFC_F_EQEN 6
`define PIFC_F_WINDTYPE 7
`define PIFC_F_SEPTYPE 8
`define PIFC_F_GAIN 9
`define PIFC_F_COEFB 16
`define PIFC_F_EQC 16
`define PIFC_F_MONO 2
`define PIFC_F_COUNT 16

`define PIFC_MASK_CTRL 32'h000007ff
`define PIFC_MASK_COEF 32'h3fff3fff
`define PIFC_MASK_EQB 32'h00003fff
`define PIFC_RST_CTRL 32'h00000000
`define PIFC_RST_COEF 32'h00000000

`define PIFC_FRAC 13
`define PIFC_ROUND 34'sh0001000
`define PIFC_SAT_HI 21'sd32767
`define PIFC_SAT_LO (-21'sd32768)
`define PIFC_SAT_HI32 32'sd32767
`define PIFC_SAT_LO32 (-32'sd32768)
`define PIFC_GAIN12_SH 5'd2
`define PIFC_GAIN24_SH 5'd4

`endif

// ### inc/pifc_pkg.sv
// Types shared by the filter chain
package pifc_pkg;
    typedef enum logic [1:0] {
        PIFC_OFF = 2'b00,
        PIFC_PLAY = 2'b01,
        PIFC_REC = 2'b10
    } pifc_path_t;
    typedef logic signed [15:0] pifc_sample_t;
endpackage

// ### logic/pifc_fo_stage.sv
// First-order recursive stage with bypass and mute
`timescale 1ns/1ps
`include "pifc_cfg.svh"
module pifc_fo_stage (
    input wire logic clk,
    input wire logic nrst,
    input wire logic inValid,
    input wire logic enable,
    input wire logic mute,
    input wire logic clear,
    input wire pifc_pkg::pifc_sample_t x,
    input wire pifc_pkg::pifc_sample_t coefA,
    input wire pifc_pkg::pifc_sample_t coefB,
    input wire pifc_pkg::pifc_sample_t coefC,
    output logic outValid,
    output pifc_pkg::pifc_sample_t y
);
    import pifc_pkg::*;

    pifc_sample_t x1Reg;
    pifc_sample_t y1Reg;
    logic signed [33:0] acc;
    logic signed [20:0] scaled;
    pifc_sample_t filt;
    pifc_sample_t yNext;

    // numerator A,C over 1 + B z^-1
    assign acc = coefA * x + coefC * x1Reg - coefB * y1Reg + `PIFC_ROUND;
    assign scaled = 21'(acc >>> `PIFC_FRAC);
    assign filt = (scaled > `PIFC_SAT_HI) ? 16'sh7fff :
                  (scaled < `PIFC_SAT_LO) ? 16'sh8000 : scaled[15:0];
    assign yNext = enable ? filt : (mute ? 16'sh0000 : x);

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            y <= 16'sh0000;
            outValid <= 1'b0;
        end else begin
            outValid <= inValid;
            if (inValid) begin
                y <= yNext;
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            x1Reg <= 16'sh0000;
            y1Reg <= 16'sh0000;
        end else if (clear || !enable) begin
            x1Reg <= 16'sh0000;
            y1Reg <= 16'sh0000;
        end else if (inValid) begin
            x1Reg <= x;
            y1Reg <= filt;
        end
    end

    property p_bypass;
        @(posedge clk) disable iff (!nrst)
        inValid && !enable && !mute |=> y == $past(x);
    endproperty
    a_bypass: assert property (p_bypass) else $error("bypass altered sample");

    property p_mute;
        @(posedge clk) disable iff (!nrst)
        inValid && !enable && mute |=> y == 16'sh0000 && outValid;
    endproperty
    a_mute: assert property (p_mute) else $error("muted stage not silent");

    property p_zero_state;
        @(posedge clk) disable iff (!nrst)
        inValid && enable && x == 16'sh0000 && x1Reg == 16'sh0000 && y1Reg == 16'sh0000
        |=> y == 16'sh0000;
    endproperty
    a_zero_state: assert property (p_zero_state) else $error("idle filter output nonzero");
endmodule // pifc_fo_stage

// ### logic/pifc_filter_chain.sv
// Programmable first-order filter chain with Avalon-MM registers
// Functional notes
// - three first-order stages, programmable coefficients
// - path from converter power bits
// - coefficients kept across path change
// - separation emphasis only in stereo
// - separation attenuation set by its coefficients
// - compensation gain 0, +12, +24 dB
// - type bit 0 high-pass, 1 low-pass
// - disabled equalizer or wind stage passes through
// - wind, separation stages: two 14-bit coefficients
// - equalizer: 16-bit A, 14-bit B, 16-bit C
// - coefficients two's complement scaled by 2^13
// - high-pass A(1-z^-1), low-pass A(1+z^-1) over pole
// - mono mix sends (L+R)/2 both channels
//
// Our own choices: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "pifc_cfg.svh"
module pifc_filter_chain (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic recValid,
    input wire pifc_pkg::pifc_sample_t recLeft,
    input wire pifc_pkg::pifc_sample_t recRight,
    input wire logic playValid,
    input wire pifc_pkg::pifc_sample_t playLeft,
    input wire pifc_pkg::pifc_sample_t playRight,
    output logic outValid,
    output pifc_pkg::pifc_sample_t outLeft,
    output pifc_pkg::pifc_sample_t outRight
);
    import pifc_pkg::*;

    logic [31:0] ctrlReg;
    logic [31:0] windReg;
    logic [31:0] sepReg;
    logic [31:0] eqAcReg;
    logic [31:0] eqBReg;
    logic [15:0] countReg;
    pifc_path_t pathReg;
    pifc_path_t pathNext;
    logic monoOp;

    // Bus decode
    logic reqTake;
    logic wrEn;
    logic [31:0] beMask;
    logic [31:0] rdMux;
    logic [31:0] statusWord;
    assign reqTake = (avs_read || avs_write) && avs_waitrequest;
    assign wrEn = avs_write && !avs_waitrequest;
    assign beMask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                     {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    assign statusWord = {countReg, 13'h0000, monoOp, pathReg};
    assign rdMux = (avs_address == `PIFC_OFS_CTRL) ? ctrlReg :
                   (avs_address == `PIFC_OFS_WIND) ? windReg :
                   (avs_address == `PIFC_OFS_SEP) ? sepReg :
                   (avs_address == `PIFC_OFS_EQAC) ? eqAcReg :
                   (avs_address == `PIFC_OFS_EQB) ? eqBReg :
                   (avs_address == `PIFC_OFS_STATUS) ? statusWord : 32'h00000000;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [31:0] be, input logic [31:0] keep);
        merge = ((old & ~be) | (nw & be)) & keep;
    endfunction

    // One wait cycle per access
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h00000000;
        end else begin
            avs_waitrequest <= !reqTake;
            if (reqTake && avs_read) begin
                avs_readdata <= rdMux;
            end
        end
    end

    // coefficients change only by bus write
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ctrlReg <= `PIFC_RST_CTRL;
            windReg <= `PIFC_RST_COEF;
            sepReg <= `PIFC_RST_COEF;
            eqAcReg <= `PIFC_RST_COEF;
            eqBReg <= `PIFC_RST_COEF;
        end else if (wrEn) begin
            if (avs_address == `PIFC_OFS_CTRL) begin
                ctrlReg <= merge(ctrlReg, avs_writedata, beMask, `PIFC_MASK_CTRL);
            end
            if (avs_address == `PIFC_OFS_WIND) begin
                windReg <= merge(windReg, avs_writedata, beMask, `PIFC_MASK_COEF);
            end
            if (avs_address == `PIFC_OFS_SEP) begin
                sepReg <= merge(sepReg, avs_writedata, beMask, `PIFC_MASK_COEF);
            end
            if (avs_address == `PIFC_OFS_EQAC) begin
                eqAcReg <= merge(eqAcReg, avs_writedata, beMask, 32'hffffffff);
            end
            if (avs_address == `PIFC_OFS_EQB) begin
                eqBReg <= merge(eqBReg, avs_writedata, beMask, `PIFC_MASK_EQB);
            end
        end
    end

    // Control fields
    logic adcL;
    logic adcR;
    logic dacOn;
    logic mixOn;
    logic [1:0] gainSel;
    assign adcL = ctrlReg[`PIFC_F_ADCL];
    assign adcR = ctrlReg[`PIFC_F_ADCR];
    assign dacOn = ctrlReg[`PIFC_F_DAC];
    assign mixOn = ctrlReg[`PIFC_F_MIX];
    assign gainSel = ctrlReg[`PIFC_F_GAIN +: 2];
    assign monoOp = (pathReg == PIFC_REC) && !(adcL && adcR && !mixOn);

    assign pathNext = (adcL || adcR) ? PIFC_REC : (dacOn ? PIFC_PLAY : PIFC_OFF);

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pathReg <= PIFC_OFF;
        end else begin
            pathReg <= pathNext;
        end
    end

    // Source selection
    logic signed [16:0] sumLR;
    pifc_sample_t avgLR;
    pifc_sample_t recSelL;
    pifc_sample_t recSelR;
    logic [1:0][15:0] chainIn;
    logic inValid;
    logic clearAll;
    assign sumLR = 17'(recLeft) + 17'(recRight);
    assign avgLR = sumLR[16:1];
    assign recSelL = !adcL ? recRight : ((adcR && mixOn) ? avgLR : recLeft);
    assign recSelR = !adcR ? recLeft : ((adcL && mixOn) ? avgLR : recRight);
    assign chainIn[0] = (pathReg == PIFC_PLAY) ? playLeft : recSelL;
    assign chainIn[1] = (pathReg == PIFC_PLAY) ? playRight : recSelR;
    assign inValid = ((pathReg == PIFC_REC) && recValid)
                  || ((pathReg == PIFC_PLAY) && playValid);
    assign clearAll = (pathReg == PIFC_OFF);

    pifc_sample_t windA;
    pifc_sample_t windB;
    pifc_sample_t windC;
    pifc_sample_t sepA;
    pifc_sample_t sepB;
    pifc_sample_t sepC;
    pifc_sample_t equalizer_coef_a;
    pifc_sample_t equalizer_coef_b;
    pifc_sample_t equalizer_coef_c;
    assign windA = {{2{windReg[13]}}, windReg[13:0]};
    assign windB = {{2{windReg[`PIFC_F_COEFB + 13]}}, windReg[`PIFC_F_COEFB +: 14]};
    assign sepA = {{2{sepReg[13]}}, sepReg[13:0]};
    assign sepB = {{2{sepReg[`PIFC_F_COEFB + 13]}}, sepReg[`PIFC_F_COEFB +: 14]};
    assign windC = ctrlReg[`PIFC_F_WINDTYPE] ? windA : -windA;
    assign sepC = ctrlReg[`PIFC_F_SEPTYPE] ? sepA : -sepA;
    assign equalizer_coef_a = eqAcReg[15:0];
    assign equalizer_coef_c = eqAcReg[`PIFC_F_EQC +: 16];
    assign equalizer_coef_b = {{2{eqBReg[13]}}, eqBReg[13:0]};

    logic sepEnable;
    logic sepMute;
    assign sepEnable = ctrlReg[`PIFC_F_SEPEN] && !monoOp;
    assign sepMute = !ctrlReg[`PIFC_F_SEPEN];

    logic [1:0][15:0] sepOut;
    logic [1:0][15:0] eqOut;
    logic [1:0][15:0] windOut;
    logic [1:0] sepV;
    logic [1:0] eqV;
    logic [1:0] windV;

    for (genvar ch = 0; ch < 2; ch++) begin : g_chan
        pifc_fo_stage u_sep (
            .clk(clk), .nrst(nrst), .inValid(inValid), .enable(sepEnable),
            .mute(sepMute), .clear(clearAll), .x(chainIn[ch]), .coefA(sepA),
            .coefB(sepB), .coefC(sepC), .outValid(sepV[ch]), .y(sepOut[ch])
        );
        pifc_fo_stage u_eq (
            .clk(clk), .nrst(nrst), .inValid(sepV[ch]),
            .enable(ctrlReg[`PIFC_F_EQEN]), .mute(1'b0), .clear(clearAll),
            .x(sepOut[ch]), .coefA(equalizer_coef_a), .coefB(equalizer_coef_b), .coefC(equalizer_coef_c),
            .outValid(eqV[ch]), .y(eqOut[ch])
        );
        pifc_fo_stage u_wind (
            .clk(clk), .nrst(nrst), .inValid(eqV[ch]),
            .enable(ctrlReg[`PIFC_F_WINDEN]), .mute(1'b0), .clear(clearAll),
            .x(eqOut[ch]), .coefA(windA), .coefB(windB), .coefC(windC),
            .outValid(windV[ch]), .y(windOut[ch])
        );
    end

    logic [4:0] gainSh;
    assign gainSh = gainSel[1] ? `PIFC_GAIN24_SH :
                    (gainSel[0] ? `PIFC_GAIN12_SH : 5'd0);

    function automatic pifc_sample_t gainSat(input pifc_sample_t s, input logic [4:0] sh);
        logic signed [31:0] w;
        w = 32'(s) <<< sh;
        if (w > `PIFC_SAT_HI32) begin
            gainSat = 16'sh7fff;
        end else if (w < `PIFC_SAT_LO32) begin
            gainSat = 16'sh8000;
        end else begin
            gainSat = w[15:0];
        end
    endfunction

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            outValid <= 1'b0;
            outLeft <= 16'sh0000;
            outRight <= 16'sh0000;
            countReg <= 16'h0000;
        end else begin
            outValid <= windV[0] && !clearAll;
            if (windV[0]) begin
                outLeft <= gainSat(windOut[0], gainSh);
                outRight <= gainSat(windOut[1], gainSh);
                countReg <= countReg + 16'h0001;
            end
        end
    end

    property p_wait_one;
        @(posedge clk) disable iff (!nrst)
        reqTake |=> !avs_waitrequest ##1 avs_waitrequest;
    endproperty
    a_wait_one: assert property (p_wait_one) else $error("waitrequest not one cycle");

    property p_path;
        @(posedge clk) disable iff (!nrst)
        (adcL || adcR) |=> pathReg == PIFC_REC;
    endproperty
    a_path: assert property (p_path) else $error("adc power not recording");

    property p_play;
        @(posedge clk) disable iff (!nrst)
        !adcL && !adcR && dacOn && !wrEn |=> pathReg == PIFC_PLAY;
    endproperty
    a_play: assert property (p_play) else $error("dac only not playback");

    property p_keep;
        @(posedge clk) disable iff (!nrst)
        pathReg == PIFC_REC && pathNext == PIFC_PLAY && !wrEn |=> $stable(windReg)
            && $stable(sepReg) && $stable(eqAcReg) && $stable(eqBReg);
    endproperty
    a_keep: assert property (p_keep) else $error("coefficients lost on path change");

    property p_latency;
        @(posedge clk) disable iff (!nrst)
        inValid && pathNext == pathReg && !wrEn ##1 !wrEn [*3] |=> outValid;
    endproperty
    a_latency: assert property (p_latency) else $error("output not four cycles later");

    property p_mix;
        @(posedge clk) disable iff (!nrst)
        pathReg == PIFC_REC && adcL && adcR && mixOn
            |-> chainIn[0] == chainIn[1] && chainIn[0] == avgLR;
    endproperty
    a_mix: assert property (p_mix) else $error("mono mix not average");

    property p_gain0;
        @(posedge clk) disable iff (!nrst)
        windV[0] && gainSel == 2'b00 |=> outLeft == $past(windOut[0]);
    endproperty
    a_gain0: assert property (p_gain0) else $error("0dB gain altered sample");

    property p_gain24;
        @(posedge clk) disable iff (!nrst)
        windV[0] && gainSel[1] && $signed(windOut[0]) < 16'sh0800
            && $signed(windOut[0]) >= 16'shf800 |=> outLeft == {$past(windOut[0][11:0]), 4'h0};
    endproperty
    a_gain24: assert property (p_gain24) else $error("24dB gain wrong");

    property p_off;
        @(posedge clk) disable iff (!nrst)
        pathReg == PIFC_OFF |=> !outValid;
    endproperty
    a_off: assert property (p_off) else $error("output while powered down");

    c_rec: cover property (@(posedge clk) disable iff (!nrst) outValid && pathReg == PIFC_REC);
    c_play: cover property (@(posedge clk) disable iff (!nrst) outValid && pathReg == PIFC_PLAY);
    c_mix: cover property (@(posedge clk) disable iff (!nrst) inValid && monoOp && mixOn);
    c_sat: cover property (@(posedge clk) disable iff (!nrst) outValid && outLeft == 16'sh7fff);
endmodule // pifc_filter_chain

// ### tb/pifc_conv_model.sv
// Converter sample datapath model feeding both sample paths
`timescale 1ns/1ps
module pifc_conv_model (
    input wire logic clk,
    input wire logic nrst,
    input wire logic sendRec,
    input wire logic sendPlay,
    input wire logic [15:0] inLeft,
    input wire logic [15:0] inRight,
    output logic recValid,
    output logic [15:0] recLeft,
    output logic [15:0] recRight,
    output logic playValid,
    output logic [15:0] playLeft,
    output logic [15:0] playRight
);
    // Unstrobed lines invert every cycle instead of holding the sample
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            recValid <= 1'b0;
            playValid <= 1'b0;
            recLeft <= 16'h0000;
            recRight <= 16'h0000;
            playLeft <= 16'h0000;
            playRight <= 16'h0000;
        end else begin
            recValid <= sendRec;
            playValid <= sendPlay;
            recLeft <= sendRec ? inLeft : ~recLeft;
            recRight <= sendRec ? inRight : ~recRight;
            playLeft <= sendPlay ? inLeft : ~playLeft;
            playRight <= sendPlay ? inRight : ~playRight;
        end
    end
endmodule // pifc_conv_model

// ### tb/pifc_filter_chain_tb_top.sv
// Self-checking bench for the filter chain
`timescale 1ns/1ps
module pifc_filter_chain_tb_top;
    import pifc_pkg::*;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [4:0] avs_address = 5'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h00000000;
    logic [3:0] avs_byteenable = 4'hf;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic sendRec = 1'b0;
    logic sendPlay = 1'b0;
    logic [15:0] inLeft = 16'h0000;
    logic [15:0] inRight = 16'h0000;
    logic recValid, playValid, outValid;
    pifc_sample_t recLeft, recRight, playLeft, playRight, outLeft, outRight;
    int error_cnt = 0;
    int comparisons = 0;
    int cycles = 0;
    int outCnt = 0;
    int ctrl = 0;
    int hx[3][2], hy[3][2];
    int cA[3] = '{4096, 6000, 3584};
    int cB[3] = '{-2048, -4000, -1024};
    int equalizer_coef_c = -3000;
    logic [31:0] cw[4];
    int sl[6] = '{0, 1000, 30000, -32768, -12345, 7};
    int sr[6] = '{0, -2000, 32767, 5, 12000, -7};
    int rows[16] = '{'h003, 'h023, 'h123, 'h163, 'h1b3, 'h033, 'h223, 'h423,
        'h623, 'h01b, 'h03b, 'h021, 'h022, 'h3f4, 'h5f7, 'h020};
    int expMask[7] = '{0, 'h3fff3fff, 'h3fff3fff, 'hffffffff, 'h3fff, 0, 0};

    pifc_filter_chain dut (.clk, .nrst, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
        .recValid, .recLeft, .recRight, .playValid, .playLeft, .playRight,
        .outValid, .outLeft, .outRight);
    pifc_conv_model conv (.clk, .nrst, .sendRec, .sendPlay, .inLeft, .inRight,
        .recValid, .recLeft, .recRight, .playValid, .playLeft, .playRight);

    initial begin
        forever #2 clk = ~clk;
    end

    task automatic close_out();
        if (error_cnt == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (outValid === 1'b1)
            outCnt++;
        if (cycles == 20000) begin
            error_cnt++;
            close_out();
        end
    end

    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic bus(logic wr, logic [4:0] a, logic [31:0] d, output logic [31:0] q);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        @(posedge clk);
        while (avs_waitrequest !== 1'b0)
            @(posedge clk);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(logic [4:0] a, logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rd_chk(string what, logic [4:0] a, logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h00000000, q);
        check(what, q, exp);
    endtask

    task automatic set_ctrl(int v);
        wr(5'h00, v);
        ctrl = v;
        foreach (hx[i, j]) begin
            hx[i][j] = 0;
            hy[i][j] = 0;
        end
    endtask

    function automatic int sat(longint v);
        return v > 32767 ? 32767 : v < -32768 ? -32768 : int'(v);
    endfunction

    function automatic int fo(int x, int x1, int y1, int a, int b, int c);
        return sat((longint'(a) * x + longint'(c) * x1 - longint'(b) * y1 + 4096) >>> 13);
    endfunction

    function automatic logic en(int s);
        return s == 0 ? ctrl[5] : s == 1 ? ctrl[6] : ctrl[4];
    endfunction

    // Reference chain: separation, equalizer, wind, gain
    task automatic ref_step(int l, int r, output int el, output int er);
        int v[2];
        int t;
        int c;
        logic rec;
        logic mono;
        rec = ctrl[1:0] != 2'b00;
        mono = rec && (ctrl[1:0] != 2'b11 || ctrl[3]);
        if (!rec || (ctrl[1:0] == 2'b11 && !ctrl[3]))
            v = '{l, r};
        else if (ctrl[1:0] == 2'b11)
            v = '{(l + r) >>> 1, (l + r) >>> 1};
        else begin
            v[0] = ctrl[0] ? l : r;
            v[1] = v[0];
        end
        for (int ch = 0; ch < 2; ch++) begin
            for (int s = 0; s < 3; s++) begin
                c = s == 1 ? equalizer_coef_c : ctrl[s == 0 ? 8 : 7] ? cA[s] : -cA[s];
                if (!en(s)) begin
                    t = s == 0 ? 0 : v[ch];
                end else if (s == 0 && mono) begin
                    t = v[ch];
                end else begin
                    t = fo(v[ch], hx[s][ch], hy[s][ch], cA[s], cB[s], c);
                    hx[s][ch] = v[ch];
                    hy[s][ch] = t;
                end
                v[ch] = t;
            end
            v[ch] = sat(longint'(v[ch]) * (ctrl[10:9] == 0 ? 1 : ctrl[10:9] == 1 ? 4 : 16));
        end
        el = v[0];
        er = v[1];
    endtask

    task automatic send(logic play, int l, int r);
        int el, er, seen;
        logic live;
        live = play ? (ctrl[1:0] == 2'b00 && ctrl[2]) : (ctrl[1:0] != 2'b00);
        if (live)
            ref_step(l, r, el, er);
        inLeft <= l[15:0];
        inRight <= r[15:0];
        sendRec <= !play;
        sendPlay <= play;
        @(posedge clk);
        sendRec <= 1'b0;
        sendPlay <= 1'b0;
        seen = 0;
        repeat (10) begin
            @(posedge clk);
            if (outValid === 1'b1) begin
                seen++;
                check("left", {16'h0000, outLeft}, {16'h0000, el[15:0]});
                check("right", {16'h0000, outRight}, {16'h0000, er[15:0]});
            end
        end
        check("outputs", seen, live);
    endtask

    initial begin
        repeat (5) @(posedge clk);
        check("reset wait", avs_waitrequest, 32'h1);
        @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        for (int i = 0; i < 7; i++)
            rd_chk("reset reg", 5'(i * 4), 32'h00000000);
        for (int i = 1; i < 7; i++)
            wr(5'(i * 4), 32'hffffffff);
        for (int i = 0; i < 7; i++)
            rd_chk("reg mask", 5'(i * 4), expMask[i]);
        avs_byteenable <= 4'h1;
        wr(5'h00, 32'hffffffff);
        avs_byteenable <= 4'hf;
        rd_chk("ctrl lane", 5'h00, 32'h000000ff);
        for (int p = 0; p < 8; p++) begin
            set_ctrl(p);
            rd_chk("status", 5'h14, {29'h0, p[1:0] == 1 || p[1:0] == 2,
                p[1:0] != 0 ? 2'b10 : p[2] ? 2'b01 : 2'b00});
        end
        set_ctrl(0);
        cw = '{{2'b00, cB[2][13:0], 2'b00, cA[2][13:0]}, {2'b00, cB[0][13:0], 2'b00,
            cA[0][13:0]}, {equalizer_coef_c[15:0], cA[1][15:0]}, {18'h0, cB[1][13:0]}};
        for (int i = 0; i < 4; i++)
            wr(5'(i * 4 + 4), cw[i]);
        foreach (rows[k]) begin
            set_ctrl(rows[k]);
            send(rows[k][1:0] != 0, 3000, -3000);
            foreach (sl[i])
                send(rows[k][1:0] == 0, sl[i], sr[i]);
            set_ctrl(0);
        end
        set_ctrl(4);
        for (int i = 0; i < 4; i++)
            rd_chk("coef kept", 5'(i * 4 + 4), cw[i]);
        rd_chk("count", 5'h14, {outCnt[15:0], 16'h0001});
        close_out();
    end
endmodule // pifc_filter_chain_tb_top
